// [io_host_pkg.sv]
// constants, field layouts and enumerations for the i/o bus host controller
// assumes a 50 MHz core clock; all bus lines are active low outside the host
package io_host_pkg;

  localparam int CLK_NS = 20;

  // timing
  localparam int SELECT_MIN_NS = 350;
  localparam int SELECT_MIN_CYCLES = (SELECT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int US_NS = 1000;
  localparam int TICK_CYCLES = US_NS / CLK_NS;
  localparam int REPLY_TIMEOUT_US = 30;
  localparam int WIPE_NS = 1000;
  localparam int WIPE_CYCLES = (WIPE_NS + CLK_NS - 1) / CLK_NS;

  // register offsets (byte addresses on the command port)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STAT_OFFSET = 8'h04;
  localparam logic [7:0] RESULT_OFFSET = 8'h08;
  localparam logic [7:0] BUF_OFFSET = 8'h0c;

  // control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BYTE_LSB = 8;
  localparam int CTRL_START_LSB = 16;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_CARRY_BIT = 2;
  localparam int STAT_SKIP_BIT = 3;
  localparam int STAT_ATTN_BIT = 4;
  localparam int STAT_ERR_BIT = 5;

  // result register fields
  localparam int RESULT_BYTE_LSB = 0;
  localparam int RESULT_COUNT_LSB = 8;

  // device status byte layout
  localparam int DEV_BUSY_BIT = 4;
  localparam int DEV_ERR_LSB = 5;
  localparam int DEV_ERR_MSB = 7;

  // reset values
  localparam logic [7:0] LINES_IDLE = 8'hff;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  typedef enum logic [3:0] {
    OP_SELECT,
    OP_OUTPUT_COMMAND,
    OP_WRITE_BYTE,
    OP_SENSE,
    OP_READ_BYTE,
    OP_INTERRUPT_ACK,
    OP_TEST_READ_SKIP,
    OP_TEST_WRITE_SKIP,
    OP_BLOCK_READ,
    OP_SYSTEM_WIPE
  } op_t;

  typedef enum logic [2:0] {
    LN_SELECT,
    LN_COMMAND,
    LN_OUT_BYTE,
    LN_STATUS,
    LN_IN_BYTE,
    LN_GRANT
  } line_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ASSERT,
    ST_DROP,
    ST_WAITREL,
    ST_WIPE
  } state_t;

endpackage : io_host_pkg

// [sync_stages.sv]
// two-flop synchroniser for a group of asynchronous bus inputs
// assumes each bit settles independently; reset value is the idle level
`timescale 1ns/1ns
`default_nettype none
module sync_stages #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_reg <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      stage1_reg <= din;
      dout <= stage1_reg;
    end
  end

endmodule : sync_stages
`default_nettype wire

// [tick_divider.sv]
// divider giving a one-cycle enable pulse every DIV cycles
// assumes clear is held while the timed interval is not running
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
  parameter int DIV = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  output logic tick
);

  localparam int CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] count_reg;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count_reg <= '0;
      tick <= 1'b0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + CW'(1);
      tick <= 1'b0;
    end
  end

endmodule : tick_divider
`default_nettype wire

// [io_bus_host.sv]
// processor-side controller for the asynchronous request/reply i/o bus
// assumes device controllers on the far side; all bus pins active low
// Functional notes
// - select: drive device number on outbound lines, then assert select strobe
// - on reply drop select strobe first, then the byte; wait reply release
// - no reply in about 30 us: abort, set carry flag
// - select strobe held at least 350 ns
// - latch returned byte on reply, only then release the line
// - exchange data only while device status bits 4 to 7 read zero; only the test ops check this, plain read and write byte ops do not
// - after capturing number drop grant; device then drops reply
// - test ops: status bit 5, 6 or 7 set loads status, no skip
// - busy only: hold query until busy clears, then read request
// - write variant: after status reply release send byte with strobe
// - successful test-and-transfer sets the skip indication
// - block read repeats test-and-read into buffer until page end
// - busy is status bit 4, errors bits 5 to 7
// - every bus line is active low
`timescale 1ns/1ns
`default_nettype none
module io_bus_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic [7:0] outboundByteLinesN,
  output logic selectStrobeN,
  output logic commandStrobeN,
  output logic outboundByteStrobeN,
  output logic statusQueryN,
  output logic inboundByteRequestN,
  output logic grantOutN,
  output logic systemWipeN,
  input wire logic [7:0] returnByteLinesN,
  input wire logic handshakeReplyN,
  input wire logic attentionLineN
);

  // strobe pin stays low at least as many cycles as this threshold
  localparam logic [4:0] SEL_LAST = 5'(io_host_pkg::SELECT_MIN_CYCLES);
  localparam logic [4:0] TIMEOUT_LAST = 5'(io_host_pkg::REPLY_TIMEOUT_US - 1);
  localparam logic [5:0] WIPE_LAST = 6'(io_host_pkg::WIPE_CYCLES - 1);

  io_host_pkg::state_t state_reg;
  io_host_pkg::op_t op_reg;
  io_host_pkg::line_t line_reg;
  logic lineOn_reg;
  logic byteOn_reg;
  logic [7:0] byteOut_reg;
  logic [4:0] width_reg;
  logic [4:0] timeout_reg;
  logic [5:0] wipeCnt_reg;
  logic [7:0] ptr_reg;
  logic [8:0] count_reg;
  logic [7:0] result_reg;
  logic err_reg;
  logic done_reg;
  logic carry_reg;
  logic skip_reg;
  logic wipeOn_reg;
  logic [7:0] bufIdx_reg;
  logic [7:0] pageBuf [0:255];

  logic [9:0] syncedN;
  logic replySeen;
  logic attnSeen;
  logic [7:0] retByte;
  logic usTick;
  logic testOp;
  logic outbound;
  logic timeoutHit;
  logic bufWrite;
  logic startOk;

  sync_stages #(
    .WIDTH(10),
    .RESET_VAL(10'h3ff)
  ) u_sync (
    .clk(core_clk),
    .rst(rst),
    .din({attentionLineN, handshakeReplyN, returnByteLinesN}),
    .dout(syncedN)
  );

  // lines are active low; flip once here
  assign attnSeen = ~syncedN[9];
  assign replySeen = ~syncedN[8];
  assign retByte = ~syncedN[7:0];

  tick_divider #(
    .DIV(io_host_pkg::TICK_CYCLES)
  ) u_tick (
    .clk(core_clk),
    .rst(rst),
    .clear(state_reg != io_host_pkg::ST_ASSERT),
    .tick(usTick)
  );

  assign testOp = (op_reg == io_host_pkg::OP_TEST_READ_SKIP) ||
                  (op_reg == io_host_pkg::OP_TEST_WRITE_SKIP) ||
                  (op_reg == io_host_pkg::OP_BLOCK_READ);
  assign outbound = (line_reg == io_host_pkg::LN_SELECT) ||
                    (line_reg == io_host_pkg::LN_COMMAND) ||
                    (line_reg == io_host_pkg::LN_OUT_BYTE);
  // timeout only while the reply is still missing
  assign timeoutHit = (state_reg == io_host_pkg::ST_ASSERT) && !replySeen &&
                      usTick && (timeout_reg == TIMEOUT_LAST);
  assign bufWrite = (state_reg == io_host_pkg::ST_WAITREL) && !replySeen &&
                    (op_reg == io_host_pkg::OP_BLOCK_READ) &&
                    (line_reg == io_host_pkg::LN_IN_BYTE);
  assign startOk = regWrite && (regAddr == io_host_pkg::CTRL_OFFSET) &&
                   (state_reg == io_host_pkg::ST_IDLE) &&
                   (regWdata[io_host_pkg::CTRL_OP_LSB +: 4] <= io_host_pkg::OP_SYSTEM_WIPE);

  function automatic io_host_pkg::line_t first_line(input io_host_pkg::op_t op);
    case (op)
      io_host_pkg::OP_SELECT: first_line = io_host_pkg::LN_SELECT;
      io_host_pkg::OP_OUTPUT_COMMAND: first_line = io_host_pkg::LN_COMMAND;
      io_host_pkg::OP_WRITE_BYTE: first_line = io_host_pkg::LN_OUT_BYTE;
      io_host_pkg::OP_READ_BYTE: first_line = io_host_pkg::LN_IN_BYTE;
      io_host_pkg::OP_INTERRUPT_ACK: first_line = io_host_pkg::LN_GRANT;
      default: first_line = io_host_pkg::LN_STATUS;
    endcase
  endfunction : first_line

  // sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= io_host_pkg::ST_IDLE;
      op_reg <= io_host_pkg::OP_SELECT;
      line_reg <= io_host_pkg::LN_SELECT;
      lineOn_reg <= 1'b0;
      byteOn_reg <= 1'b0;
      byteOut_reg <= io_host_pkg::BYTE_RESET;
      width_reg <= 5'h00;
      timeout_reg <= 5'h00;
      wipeCnt_reg <= 6'h00;
      ptr_reg <= 8'h00;
      count_reg <= 9'h000;
      result_reg <= io_host_pkg::BYTE_RESET;
      err_reg <= 1'b0;
      done_reg <= 1'b0;
      carry_reg <= 1'b0;
      skip_reg <= 1'b0;
      wipeOn_reg <= 1'b0;
    end else begin
      case (state_reg)
        io_host_pkg::ST_IDLE: begin
          if (startOk) begin
            op_reg <= io_host_pkg::op_t'(regWdata[io_host_pkg::CTRL_OP_LSB +: 4]);
            line_reg <= first_line(io_host_pkg::op_t'(regWdata[io_host_pkg::CTRL_OP_LSB +: 4]));
            byteOut_reg <= regWdata[io_host_pkg::CTRL_BYTE_LSB +: 8];
            ptr_reg <= regWdata[io_host_pkg::CTRL_START_LSB +: 8];
            count_reg <= 9'h000;
            err_reg <= 1'b0;
            done_reg <= 1'b0;
            carry_reg <= 1'b0;
            skip_reg <= 1'b0;
            if (regWdata[io_host_pkg::CTRL_OP_LSB +: 4] == io_host_pkg::OP_SYSTEM_WIPE) begin
              wipeOn_reg <= 1'b1;
              wipeCnt_reg <= 6'h00;
              state_reg <= io_host_pkg::ST_WIPE;
            end else begin
              state_reg <= io_host_pkg::ST_SETUP;
            end
          end
        end
        io_host_pkg::ST_SETUP: begin
          // byte goes out one cycle ahead of its strobe
          byteOn_reg <= outbound;
          state_reg <= io_host_pkg::ST_ASSERT;
          width_reg <= 5'h00;
          timeout_reg <= 5'h00;
        end
        io_host_pkg::ST_ASSERT: begin
          lineOn_reg <= 1'b1;
          if (width_reg != 5'h1f) begin
            width_reg <= width_reg + 5'h01;
          end
          if (usTick) begin
            timeout_reg <= timeout_reg + 5'h01;
          end
          if (timeoutHit) begin
            carry_reg <= 1'b1;
            done_reg <= 1'b1;
            lineOn_reg <= 1'b0;
            byteOn_reg <= 1'b0;
            state_reg <= io_host_pkg::ST_IDLE;
          end else if (replySeen && lineOn_reg) begin
            if (outbound) begin
              if (line_reg != io_host_pkg::LN_SELECT || width_reg >= SEL_LAST) begin
                lineOn_reg <= 1'b0;
                state_reg <= io_host_pkg::ST_DROP;
              end
            end else if (line_reg == io_host_pkg::LN_STATUS && testOp) begin
              if (|retByte[io_host_pkg::DEV_ERR_MSB:io_host_pkg::DEV_ERR_LSB]) begin
                result_reg <= retByte;
                err_reg <= 1'b1;
                lineOn_reg <= 1'b0;
                state_reg <= io_host_pkg::ST_WAITREL;
              end else if (!retByte[io_host_pkg::DEV_BUSY_BIT]) begin
                result_reg <= retByte;
                lineOn_reg <= 1'b0;
                state_reg <= io_host_pkg::ST_WAITREL;
              end
            end else begin
              // status, inbound byte or device number
              result_reg <= retByte;
              lineOn_reg <= 1'b0;
              state_reg <= io_host_pkg::ST_WAITREL;
            end
          end
        end
        io_host_pkg::ST_DROP: begin
          byteOn_reg <= 1'b0;
          state_reg <= io_host_pkg::ST_WAITREL;
        end
        io_host_pkg::ST_WAITREL: begin
          if (!replySeen) begin
            if (testOp && line_reg == io_host_pkg::LN_STATUS && !err_reg) begin
              if (op_reg == io_host_pkg::OP_TEST_WRITE_SKIP) begin
                line_reg <= io_host_pkg::LN_OUT_BYTE;
              end else begin
                line_reg <= io_host_pkg::LN_IN_BYTE;
              end
              state_reg <= io_host_pkg::ST_SETUP;
            end else if (bufWrite) begin
              ptr_reg <= ptr_reg + 8'h01;
              count_reg <= count_reg + 9'h001;
              if (ptr_reg == 8'hff) begin
                done_reg <= 1'b1;
                state_reg <= io_host_pkg::ST_IDLE;
              end else begin
                line_reg <= io_host_pkg::LN_STATUS;
                state_reg <= io_host_pkg::ST_SETUP;
              end
            end else begin
              skip_reg <= !err_reg && ((op_reg == io_host_pkg::OP_TEST_READ_SKIP) ||
                          (op_reg == io_host_pkg::OP_TEST_WRITE_SKIP));
              done_reg <= 1'b1;
              state_reg <= io_host_pkg::ST_IDLE;
            end
          end
        end
        io_host_pkg::ST_WIPE: begin
          wipeCnt_reg <= wipeCnt_reg + 6'h01;
          if (wipeCnt_reg == WIPE_LAST) begin
            wipeOn_reg <= 1'b0;
            done_reg <= 1'b1;
            state_reg <= io_host_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= io_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // pins follow the sequencer one cycle later, inverted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outboundByteLinesN <= io_host_pkg::LINES_IDLE;
      selectStrobeN <= 1'b1;
      commandStrobeN <= 1'b1;
      outboundByteStrobeN <= 1'b1;
      statusQueryN <= 1'b1;
      inboundByteRequestN <= 1'b1;
      grantOutN <= 1'b1;
      systemWipeN <= 1'b1;
    end else begin
      outboundByteLinesN <= byteOn_reg ? ~byteOut_reg : io_host_pkg::LINES_IDLE;
      selectStrobeN <= !(lineOn_reg && line_reg == io_host_pkg::LN_SELECT);
      commandStrobeN <= !(lineOn_reg && line_reg == io_host_pkg::LN_COMMAND);
      outboundByteStrobeN <= !(lineOn_reg && line_reg == io_host_pkg::LN_OUT_BYTE);
      statusQueryN <= !(lineOn_reg && line_reg == io_host_pkg::LN_STATUS);
      inboundByteRequestN <= !(lineOn_reg && line_reg == io_host_pkg::LN_IN_BYTE);
      grantOutN <= !(lineOn_reg && line_reg == io_host_pkg::LN_GRANT);
      systemWipeN <= !wipeOn_reg;
    end
  end

  // page buffer for block reads
  always_ff @(posedge core_clk) begin
    if (bufWrite) begin
      pageBuf[ptr_reg] <= result_reg;
    end
  end

  // buffer read index: set by write, steps on each read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bufIdx_reg <= 8'h00;
    end else if (regWrite && regAddr == io_host_pkg::BUF_OFFSET) begin
      bufIdx_reg <= regWdata[7:0];
    end else if (regRead && regAddr == io_host_pkg::BUF_OFFSET) begin
      bufIdx_reg <= bufIdx_reg + 8'h01;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      regRdata <= io_host_pkg::RDATA_RESET;
    end else begin
      regRdata <= io_host_pkg::RDATA_RESET;
      if (regRead) begin
        case (regAddr)
          io_host_pkg::STAT_OFFSET: begin
            regRdata[io_host_pkg::STAT_BUSY_BIT] <= state_reg != io_host_pkg::ST_IDLE;
            regRdata[io_host_pkg::STAT_DONE_BIT] <= done_reg;
            regRdata[io_host_pkg::STAT_CARRY_BIT] <= carry_reg;
            regRdata[io_host_pkg::STAT_SKIP_BIT] <= skip_reg;
            regRdata[io_host_pkg::STAT_ATTN_BIT] <= attnSeen;
            regRdata[io_host_pkg::STAT_ERR_BIT] <= err_reg;
          end
          io_host_pkg::RESULT_OFFSET: begin
            regRdata[io_host_pkg::RESULT_BYTE_LSB +: 8] <= result_reg;
            regRdata[io_host_pkg::RESULT_COUNT_LSB +: 9] <= count_reg;
          end
          io_host_pkg::BUF_OFFSET: begin
            regRdata[7:0] <= pageBuf[bufIdx_reg];
          end
          default: begin
            regRdata <= io_host_pkg::RDATA_RESET;
          end
        endcase
      end
    end
  end

endmodule : io_bus_host
`default_nettype wire

// [io_bus_host_checker.sv]
// concurrent checks on the pins of the i/o bus host controller
// assumes one core clock, synchronous active-high reset, bus pins active low
`timescale 1ns/1ns
`default_nettype none
module io_bus_host_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic [7:0] outboundByteLinesN,
  input wire logic selectStrobeN,
  input wire logic commandStrobeN,
  input wire logic outboundByteStrobeN,
  input wire logic statusQueryN,
  input wire logic inboundByteRequestN,
  input wire logic grantOutN,
  input wire logic [7:0] returnByteLinesN,
  input wire logic handshakeReplyN
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic anyLine;
  logic testOp;
  logic [15:0] selLow;
  logic [15:0] noReply;
  assign anyLine = !(selectStrobeN && commandStrobeN && outboundByteStrobeN && statusQueryN
    && inboundByteRequestN && grantOutN);
  // busy hold only applies to the combined test ops, plain sense releases at once
  always_ff @(posedge core_clk) begin
    if (rst) begin
      selLow <= 16'h0000;
      noReply <= 16'h0000;
      testOp <= 1'b0;
    end else begin
      selLow <= selectStrobeN ? 16'h0000 : selLow + 16'h0001;
      noReply <= (anyLine && handshakeReplyN) ? noReply + 16'h0001 : 16'h0000;
      if (regWrite && regAddr == io_host_pkg::CTRL_OFFSET) testOp <= regWdata[3:0] inside {4'h6, 4'h7, 4'h8};
    end
  end
  property p_idle;
    $fell(rst) |-> selectStrobeN && commandStrobeN && outboundByteStrobeN && statusQueryN
      && inboundByteRequestN && grantOutN && outboundByteLinesN == 8'hff;
  endproperty
  a_idle: assert property (p_idle) else $error("bus not idle after reset");
  property p_sel_width;
    $rose(selectStrobeN) |-> selLow >= 16'(io_host_pkg::SELECT_MIN_CYCLES);
  endproperty
  a_sel_width: assert property (p_sel_width) else $error("select strobe too short");
  property p_sel_byte;
    !selectStrobeN |-> $stable(outboundByteLinesN);
  endproperty
  a_sel_byte: assert property (p_sel_byte) else $error("byte moved under select strobe");
  property p_release_order;
    ($rose(selectStrobeN) || $rose(commandStrobeN) || $rose(outboundByteStrobeN)) && !handshakeReplyN
      |-> $stable(outboundByteLinesN) ##1 outboundByteLinesN == 8'hff;
  endproperty
  a_release_order: assert property (p_release_order) else $error("byte not released after strobe");
  property p_timeout;
    anyLine |-> noReply < 16'd2000;
  endproperty
  a_timeout: assert property (p_timeout) else $error("line held too long without reply");
  property p_busy_hold;
    (testOp && !statusQueryN && !handshakeReplyN && !returnByteLinesN[4] && returnByteLinesN[7:5] == 3'b111)[*2]
      |=> !statusQueryN;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("query dropped while device busy");
  property p_err_stop;
    (!statusQueryN && !handshakeReplyN && returnByteLinesN[7:5] != 3'b111)[*2]
      |-> ##[1:6] statusQueryN ##0 (inboundByteRequestN && outboundByteStrobeN)[*8];
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("transfer after error status");
  property p_reply_first;
    ($fell(outboundByteStrobeN) || $fell(inboundByteRequestN)) |-> handshakeReplyN && $past(handshakeReplyN);
  endproperty
  a_reply_first: assert property (p_reply_first) else $error("transfer before reply released");
endmodule : io_bus_host_checker
bind io_bus_host io_bus_host_checker io_bus_host_checker_i (.core_clk(core_clk), .rst(rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .outboundByteLinesN(outboundByteLinesN),
  .selectStrobeN(selectStrobeN), .commandStrobeN(commandStrobeN), .outboundByteStrobeN(outboundByteStrobeN),
  .statusQueryN(statusQueryN), .inboundByteRequestN(inboundByteRequestN), .grantOutN(grantOutN),
  .returnByteLinesN(returnByteLinesN), .handshakeReplyN(handshakeReplyN));
`default_nettype wire

// [io_device_model.sv]
// behavioural device controller on the far side of the host bus
// assumes it samples the host's registered pins on the host clock; lines active low
`timescale 1ns/1ns
`default_nettype none
module io_device_model #(
  parameter logic [7:0] DEV_NUM = 8'h5a
) (
  input wire logic clk,
  input wire logic [7:0] outN,
  input wire logic selN,
  input wire logic cmdN,
  input wire logic obsN,
  input wire logic sqN,
  input wire logic ibrN,
  input wire logic grantInN,
  input wire logic wipeN,
  input wire logic [7:0] statusByte,
  input wire logic [7:0] inByte,
  input wire logic raiseIrq,
  input wire logic slow,
  output logic [7:0] retN,
  output logic replyN,
  output logic attnN,
  output logic grantDownN,
  output logic selected,
  output logic [7:0] cmdByte,
  output logic [7:0] dataByte
);
  logic pend = 1'b0;
  logic ackHit = 1'b0;
  logic [7:0] waitCnt = 8'h00;
  logic [7:0] limit;
  logic want;
  initial begin
    selected = 1'b0;
    replyN = 1'b1;
    cmdByte = 8'h00;
    dataByte = 8'h00;
  end
  assign limit = slow ? 8'd40 : 8'd0;
  assign want = (!selN && ~outN == DEV_NUM) || (selected && !(cmdN && obsN && sqN && ibrN))
    || (!grantInN && (pend || ackHit));
  always @(posedge clk) begin
    if (!want) waitCnt <= 8'h00;
    else if (waitCnt < limit) waitCnt <= waitCnt + 8'd1;
    replyN <= !(want && waitCnt >= limit);
    if (!wipeN) begin
      selected <= 1'b0;
      pend <= 1'b0;
      ackHit <= 1'b0;
    end else begin
      if (!selN) selected <= (~outN == DEV_NUM);
      if (selected && !cmdN) cmdByte <= ~outN;
      if (selected && !obsN) dataByte <= ~outN;
      if (raiseIrq) pend <= 1'b1;
      if (!grantInN && pend) begin
        pend <= 1'b0;
        ackHit <= 1'b1;
      end
      if (grantInN) ackHit <= 1'b0;
    end
  end
  // undriven return lines float to the host's pull-up level
  assign retN = (selected && !sqN) ? ~statusByte : (selected && !ibrN) ? ~inByte
    : ackHit ? ~DEV_NUM : 8'hff;
  assign attnN = ~pend;
  assign grantDownN = grantInN | pend | ackHit;
endmodule : io_device_model
`default_nettype wire

// [testbench.sv]
// register-level tests of the i/o bus host against one device model
// assumes the host's register map and op codes from the package
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [7:0] DEV = 8'h5a;
  localparam logic [7:0] STAT = io_host_pkg::STAT_OFFSET;
  localparam logic [7:0] RES = io_host_pkg::RESULT_OFFSET;
  localparam logic [31:0] DONE = 32'h1 << io_host_pkg::STAT_DONE_BIT;
  localparam logic [31:0] CARRY = 32'h1 << io_host_pkg::STAT_CARRY_BIT;
  localparam logic [31:0] SKIP = 32'h1 << io_host_pkg::STAT_SKIP_BIT;
  localparam logic [31:0] ATTN = 32'h1 << io_host_pkg::STAT_ATTN_BIT;
  localparam logic [31:0] ERR = 32'h1 << io_host_pkg::STAT_ERR_BIT;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] devStatus = 8'h00;
  logic raiseIrq = 1'b0;
  logic slow = 1'b0;
  logic [31:0] regRdata, rdv;
  logic [7:0] outN, retN, devCmd, devData;
  logic selN, cmdN, obsN, sqN, ibrN, grN, wipeN, repN, atnN, devSel;
  int mismatches = 0;
  int checksDone = 0;
  int cycles = 0;
  io_bus_host io_bus_host_i (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .outboundByteLinesN(outN),
    .selectStrobeN(selN), .commandStrobeN(cmdN), .outboundByteStrobeN(obsN), .statusQueryN(sqN),
    .inboundByteRequestN(ibrN), .grantOutN(grN), .systemWipeN(wipeN), .returnByteLinesN(retN),
    .handshakeReplyN(repN), .attentionLineN(atnN));
  io_device_model #(.DEV_NUM(DEV)) io_device_model_i (.clk(core_clk), .outN(outN), .selN(selN), .cmdN(cmdN),
    .obsN(obsN), .sqN(sqN), .ibrN(ibrN), .grantInN(grN), .wipeN(wipeN), .statusByte(devStatus),
    .inByte(8'h96), .raiseIrq(raiseIrq), .slow(slow), .retN(retN), .replyN(repN), .attnN(atnN),
    .grantDownN(), .selected(devSel), .cmdByte(devCmd), .dataByte(devData));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  task automatic summarize();
    if (mismatches == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic start(input io_host_pkg::op_t o, input logic [7:0] b, input logic [7:0] p,
      input logic [7:0] st, input logic sl);
    @(posedge core_clk);
    devStatus <= st;
    slow <= sl;
    wr(io_host_pkg::CTRL_OFFSET, {8'h00, p, b, 4'h0, o});
  endtask : start
  task automatic wait_idle(input logic [31:0] exp);
    int n;
    n = 0;
    rd(STAT, rdv);
    while (rdv[0] !== 1'b0 && n < 4000) begin
      rd(STAT, rdv);
      n++;
    end
    chk(rdv, exp);
  endtask : wait_idle
  task automatic op(input io_host_pkg::op_t o, input logic [7:0] b, input logic [7:0] p,
      input logic [7:0] st, input logic sl, input logic [31:0] exp);
    start(o, b, p, st, sl);
    wait_idle(exp);
  endtask : op
  // hang guard well above the longest path, which is the single reply timeout
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(STAT, rdv); chk(rdv, 32'h0);
    rd(8'h10, rdv); chk(rdv, 32'h0);
    op(io_host_pkg::OP_SELECT, DEV, 8'h00, 8'h00, 1'b0, DONE); chk({31'h0, devSel}, 32'h1);
    op(io_host_pkg::OP_OUTPUT_COMMAND, 8'h3c, 8'h00, 8'h00, 1'b1, DONE); chk({24'h0, devCmd}, 32'h3c);
    op(io_host_pkg::OP_WRITE_BYTE, 8'ha5, 8'h00, 8'h00, 1'b0, DONE); chk({24'h0, devData}, 32'ha5);
    op(io_host_pkg::OP_SENSE, 8'h00, 8'h00, 8'hc3, 1'b0, DONE); rd(RES, rdv); chk(rdv, 32'hc3);
    op(io_host_pkg::OP_READ_BYTE, 8'h00, 8'h00, 8'h00, 1'b0, DONE); rd(RES, rdv); chk(rdv, 32'h96);
    op(io_host_pkg::OP_TEST_READ_SKIP, 8'h00, 8'h00, 8'h00, 1'b0, DONE | SKIP);
    start(io_host_pkg::OP_TEST_WRITE_SKIP, 8'h69, 8'h00, 8'h10, 1'b0);
    repeat (40) @(posedge core_clk);
    rd(STAT, rdv); chk(rdv, 32'h1);
    wr(io_host_pkg::CTRL_OFFSET, {16'h0000, 8'h11, 4'h0, io_host_pkg::OP_TEST_READ_SKIP});
    @(posedge core_clk);
    devStatus <= 8'h00;
    wait_idle(DONE | SKIP); chk({24'h0, devData}, 32'h69);
    op(io_host_pkg::OP_TEST_READ_SKIP, 8'h00, 8'h00, 8'h40, 1'b0, DONE | ERR);
    rd(RES, rdv); chk(rdv, 32'h40);
    op(io_host_pkg::OP_BLOCK_READ, 8'h00, 8'hfe, 8'h00, 1'b0, DONE);
    rd(RES, rdv); chk(rdv, (32'd2 << io_host_pkg::RESULT_COUNT_LSB) | 32'h96);
    wr(io_host_pkg::BUF_OFFSET, 32'hfe);
    rd(io_host_pkg::BUF_OFFSET, rdv); chk(rdv, 32'h96);
    rd(io_host_pkg::BUF_OFFSET, rdv); chk(rdv, 32'h96);
    @(posedge core_clk);
    raiseIrq <= 1'b1;
    @(posedge core_clk);
    raiseIrq <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd(STAT, rdv); chk(rdv, DONE | ATTN);
    op(io_host_pkg::OP_INTERRUPT_ACK, 8'h00, 8'h00, 8'h00, 1'b0, DONE);
    rd(RES, rdv); chk(rdv, {24'h0, DEV});
    op(io_host_pkg::OP_SELECT, 8'h11, 8'h00, 8'h00, 1'b0, DONE | CARRY);
    chk({31'h0, devSel}, 32'h0);
    op(io_host_pkg::OP_SELECT, DEV, 8'h00, 8'h00, 1'b0, DONE);
    op(io_host_pkg::OP_SYSTEM_WIPE, 8'h00, 8'h00, 8'h00, 1'b0, DONE); chk({31'h0, devSel}, 32'h0);
    summarize();
  end
endmodule : testbench
`default_nettype wire
